/* File: lacr_pkg.sv */
// package for the load-adaptive current regulator: register map, fields, types
`default_nettype none
package lacr_pkg;
  // =====================================================
  // register byte offsets on the bus
  localparam logic [7:0] LACR_OFS_WORD = 8'h00;   // 20-bit config word entry
  localparam logic [7:0] LACR_OFS_STAT = 8'h04;   // status, clear on read
  localparam logic [7:0] LACR_OFS_MASK = 8'h08;   // interrupt mask
  localparam logic [7:0] LACR_OFS_SCALE = 8'h0C;  // live scaling factor
  localparam logic [7:0] LACR_OFS_LOAD = 8'h10;   // held load measurement
  // =====================================================
  // word address patterns, bits 19:17
  localparam int LACR_ADDR_HI = 19;
  localparam int LACR_ADDR_LO = 17;
  localparam logic [2:0] LACR_ADDR_ADAPT = 3'h5;  // one, zero, one
  localparam logic [2:0] LACR_ADDR_STALL = 3'h6;  // one, one, zero
  // adaptive word fields
  localparam int LACR_MINF_BIT = 15;
  localparam int LACR_DEC_HI = 14;
  localparam int LACR_DEC_LO = 13;
  localparam int LACR_UOFS_HI = 11;
  localparam int LACR_UOFS_LO = 8;
  localparam int LACR_INC_HI = 6;
  localparam int LACR_INC_LO = 5;
  localparam int LACR_LTH_HI = 3;
  localparam int LACR_LTH_LO = 0;
  // stall word fields
  localparam int LACR_FILT_BIT = 16;
  localparam int LACR_SGT_HI = 14;
  localparam int LACR_SGT_LO = 8;
  localparam int LACR_CS_HI = 4;
  localparam int LACR_CS_LO = 0;
  // threshold unit and filter spacing
  localparam int LACR_THR_SHIFT = 5;              // times 32
  localparam logic [1:0] LACR_FILT_STEPS = 2'h3;  // four full steps, counted 0..3
  // status bit positions
  localparam int LACR_ST_INC = 0;
  localparam int LACR_ST_DEC = 1;
  localparam int LACR_ST_STALL = 2;
  localparam int LACR_ST_W = 3;
  // =====================================================
  // configuration carriers
  typedef struct packed {
    logic min_quarter;       // minimum fraction is a quarter
    logic [1:0] dec_code;    // decrement sample count code
    logic [3:0] upper_ofs;   // upper threshold offset
    logic [1:0] inc_code;    // increment step size code
    logic [3:0] lower_thr;   // lower threshold, zero disables
  } lacr_adapt_type;
  typedef struct packed {
    logic filt_en;           // filtered measurement
    logic signed [6:0] stall_threshold;  // stall threshold
    logic [4:0] cs;          // current scale
  } lacr_stall_type;
endpackage
`default_nettype wire

/* File: lacr_stepper.sv */
// saturating scaling-factor stepper, one adaptive decision per sample
`default_nettype none
module lacr_stepper
  import lacr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // control
  input wire logic sample,          // qualified load sample
  input wire logic enable,          // adaptation on
  input wire logic below,           // sample under lower threshold
  input wire logic at_or_above,     // sample at or over upper threshold
  input wire lacr_adapt_type cfg,   // adaptive configuration
  input wire logic [4:0] cs,        // programmed current scale
  // result
  output logic [4:0] factor,        // adaptive scaling factor
  output logic inc_ev,              // one-cycle increment event
  output logic dec_ev               // one-cycle decrement event
);
  typedef struct packed {
    logic [4:0] factor;
    logic [5:0] hits;
    logic inc_ev;
    logic dec_ev;
  } lacr_step_state_type;
  lacr_step_state_type st, next_st;
  logic [4:0] floor_v;   // lowest allowed factor
  logic [5:0] need;      // samples needed per decrement
  logic [4:0] step;      // increment amount
  logic [5:0] sum;       // widened increment result

  // =====================================================
  // limits and step sizes
  always_comb
  begin
    // (cs+1)/2 or (cs+1)/4 expressed in factor code form
    floor_v = cfg.min_quarter ? 5'((6'(cs) + 6'h01) >> 2) : 5'((6'(cs) + 6'h01) >> 1);
    if (floor_v != 5'h00)
      floor_v = floor_v - 5'h01;
    unique case (cfg.dec_code)
      2'h0: need = 6'h20;
      2'h1: need = 6'h08;
      2'h2: need = 6'h02;
      2'h3: need = 6'h01;
    endcase
    step = 5'h01 << cfg.inc_code;
    sum = 6'(st.factor) + 6'(step);
  end

  // =====================================================
  // next state
  always_comb
  begin
    next_st = st;
    next_st.inc_ev = 1'b0;
    next_st.dec_ev = 1'b0;
    if (!enable)
    begin
      // disabled: full programmed scale
      next_st.factor = cs;
      next_st.hits = 6'h00;
    end
    else if (sample && below)
    begin
      // increase, saturate at programmed scale
      next_st.factor = (sum > 6'(cs)) ? cs : sum[4:0];
      next_st.hits = 6'h00;
      next_st.inc_ev = 1'b1;
    end
    else if (sample && at_or_above)
    begin
      if (st.hits + 6'h01 >= need)
      begin
        // enough high samples: one step down, not under the floor
        next_st.hits = 6'h00;
        next_st.factor = (st.factor > floor_v) ? st.factor - 5'h01 : floor_v;
        next_st.dec_ev = 1'b1;
      end
      else
        next_st.hits = st.hits + 6'h01;
    end
    else if (st.factor > cs)
      next_st.factor = cs;  // scale lowered by software
  end

  // =====================================================
  // state register
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end

  assign factor = st.factor;
  assign inc_ev = st.inc_ev;
  assign dec_ev = st.dec_ev;

  // =====================================================
  // checks
  property p_sat_top;
    @(posedge core_clk) disable iff (!rst_b)
      enable && sample && below |=> factor <= $past(cs);
  endproperty
  a_sat_top: assert property (p_sat_top) else $error("factor above scale");
  property p_disabled;
    @(posedge core_clk) disable iff (!rst_b)
      !enable |=> factor == $past(cs);
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled factor wrong");
  property p_inc;
    @(posedge core_clk) disable iff (!rst_b)
      enable && sample && below |=> inc_ev;
  endproperty
  a_inc: assert property (p_inc) else $error("increment missed");
  property p_dec_one;
    @(posedge core_clk) disable iff (!rst_b)
      enable && sample && !below && at_or_above && cfg.dec_code == 2'h3 |=> dec_ev;
  endproperty
  a_dec_one: assert property (p_dec_one) else $error("decrement missed");
  c_dec: cover property (@(posedge core_clk) dec_ev);
endmodule
`default_nettype wire

/* File: lacr_top.sv */
// load-adaptive current regulator: bus slave, config words, filtering, stall flag
`default_nettype none
//
// Functional notes
// - pattern 101 in bits 19:17 selects adaptive word
// - pattern 110 in bits 19:17 selects stall word
// - bit 15 picks half or quarter minimum
// - bits 14:13 give 32/8/2/1 decrement samples
// - upper threshold is (lower+offset+1) times 32
// - bits 6:5 give 1/2/4/8 increment steps
// - load under lower times 32 raises current
// - lower threshold zero disables adaptation
// - filter bit clear: every sample used
// - filter bit set: update every four steps
// - smaller threshold makes stall flag trip later, at a lower measurement
// - current scale is (field+1)/32
// - scale applies to both coil targets
//
module lacr_top
  import lacr_pkg::*;
#(
  parameter int LOAD_W = 10  // load measurement width
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // load measurement source
  input wire logic [LOAD_W-1:0] load_in,   // raw measurement
  input wire logic load_valid,             // one-cycle sample strobe
  input wire logic full_step,              // one-cycle full-step strobe
  // coil current targets
  input wire logic [7:0] coil_a_in,        // unscaled coil A target
  input wire logic [7:0] coil_b_in,        // unscaled coil B target
  output logic [7:0] coil_a_out,           // scaled coil A target
  output logic [7:0] coil_b_out,           // scaled coil B target
  // indicators
  output logic stall_indicator_out,        // load at or under stall level
  output logic irq                         // unmasked status pending
);
  initial
  begin
    if (LOAD_W < 10 || LOAD_W > 16)
      $error("LOAD_W must be 10..16");
  end

  // all state in one record
  typedef struct packed {
    logic ph_valid;                    // data phase pending
    logic ph_write;                    // pending is a write
    logic [7:0] ph_addr;               // pending byte offset
    lacr_adapt_type adapt;             // adaptive config
    lacr_stall_type stall;             // stall config
    logic [LACR_ST_W-1:0] status;      // sticky events
    logic [LACR_ST_W-1:0] mask;        // interrupt mask
    logic [1:0] step_cnt;              // full steps since last update
    logic [LOAD_W-1:0] load_meas;      // held measurement
    logic meas_new;                    // held measurement just updated
    logic [31:0] rdata;
    logic [7:0] coil_a;
    logic [7:0] coil_b;
    logic stall_flag;
    logic irq;
  } lacr_state_type;
  lacr_state_type st, next_st;

  logic [4:0] factor;                  // adaptive scale from stepper
  logic inc_ev;
  logic dec_ev;
  logic adapt_en;
  logic below;
  logic at_or_above;
  logic [LOAD_W+1:0] lower_lvl;        // lower threshold in load units
  logic [LOAD_W+1:0] upper_lvl;        // upper threshold in load units
  logic signed [LOAD_W+2:0] stall_lvl; // stall trip level
  logic addr_ok;
  logic rd_take;                       // read address phase taken this edge
  logic [31:0] rd_mux;
  logic [19:0] wword;

  // =====================================================
  // scale a coil target by (factor+1)/32
  function automatic logic [7:0] scale_coil(input logic [7:0] v, input logic [4:0] f);
    logic [13:0] prod;
    prod = 14'(v) * (14'(f) + 14'h0001);
    return prod[12:5];
  endfunction

  // =====================================================
  // thresholds
  always_comb
  begin
    adapt_en = st.adapt.lower_thr != 4'h0;
    lower_lvl = (LOAD_W+2)'(st.adapt.lower_thr) << LACR_THR_SHIFT;
    upper_lvl = ((LOAD_W+2)'(st.adapt.lower_thr) + (LOAD_W+2)'(st.adapt.upper_ofs)
                + (LOAD_W+2)'(1)) << LACR_THR_SHIFT;
    below = (LOAD_W+2)'(st.load_meas) < lower_lvl;
    at_or_above = (LOAD_W+2)'(st.load_meas) >= upper_lvl;
    // signed threshold shifts the trip point; smaller value trips at less load
    stall_lvl = (LOAD_W+3)'(st.stall.stall_threshold) + (LOAD_W+3)'(1 <<< LACR_THR_SHIFT);
  end

  // =====================================================
  // register read decode, on the address phase: with no wait state the
  // data must already stand during the data phase that follows
  always_comb
  begin
    addr_ok = 1'b1;
    rd_take = hsel && hready && htrans[1] && !hwrite;
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      LACR_OFS_WORD: rd_mux = 32'h0000_0000;  // write-only words
      LACR_OFS_STAT: rd_mux = 32'(st.status);
      LACR_OFS_MASK: rd_mux = 32'(st.mask);
      LACR_OFS_SCALE: rd_mux = 32'(factor);
      LACR_OFS_LOAD: rd_mux = 32'(st.load_meas);
      default: addr_ok = 1'b0;
    endcase
    wword = hwdata[19:0];
  end

  // =====================================================
  // next state
  always_comb
  begin
    next_st = st;
    next_st.meas_new = 1'b0;
    // address phase capture
    next_st.ph_valid = hsel && hready && htrans[1];
    if (hsel && hready && htrans[1])
    begin
      next_st.ph_write = hwrite;
      next_st.ph_addr = haddr[7:0];
    end
    // data phase
    if (st.ph_valid && st.ph_write && st.ph_addr == LACR_OFS_WORD)
    begin
      if (wword[LACR_ADDR_HI:LACR_ADDR_LO] == LACR_ADDR_ADAPT)
      begin
        next_st.adapt.min_quarter = wword[LACR_MINF_BIT];
        next_st.adapt.dec_code = wword[LACR_DEC_HI:LACR_DEC_LO];
        next_st.adapt.upper_ofs = wword[LACR_UOFS_HI:LACR_UOFS_LO];
        next_st.adapt.inc_code = wword[LACR_INC_HI:LACR_INC_LO];
        next_st.adapt.lower_thr = wword[LACR_LTH_HI:LACR_LTH_LO];
      end
      else if (wword[LACR_ADDR_HI:LACR_ADDR_LO] == LACR_ADDR_STALL)
      begin
        next_st.stall.filt_en = wword[LACR_FILT_BIT];
        next_st.stall.stall_threshold = wword[LACR_SGT_HI:LACR_SGT_LO];
        next_st.stall.cs = wword[LACR_CS_HI:LACR_CS_LO];
      end
    end
    if (st.ph_valid && st.ph_write && st.ph_addr == LACR_OFS_MASK)
      next_st.mask = hwdata[LACR_ST_W-1:0];
    // read data captured at the address edge, shown for one cycle
    next_st.rdata = 32'h0000_0000;
    if (rd_take)
      next_st.rdata = rd_mux;
    // status read clears at the same edge that captures it, so nothing
    // set later is lost; new events below win over the clear
    if (rd_take && addr_ok && haddr[7:0] == LACR_OFS_STAT)
      next_st.status = '0;
    // measurement capture, raw or every fourth full step
    if (!st.stall.filt_en)
    begin
      if (load_valid)
      begin
        next_st.load_meas = load_in;
        next_st.meas_new = 1'b1;
      end
    end
    else if (full_step)
    begin
      next_st.step_cnt = st.step_cnt + 2'h1;
      if (st.step_cnt == LACR_FILT_STEPS)
      begin
        next_st.load_meas = load_in;
        next_st.meas_new = 1'b1;
      end
    end
    // stall flag: measurement at or under trip level
    next_st.stall_flag = $signed({3'b000, st.load_meas}) <= stall_lvl;
    if (next_st.stall_flag && !st.stall_flag)
      next_st.status[LACR_ST_STALL] = 1'b1;
    if (inc_ev)
      next_st.status[LACR_ST_INC] = 1'b1;
    if (dec_ev)
      next_st.status[LACR_ST_DEC] = 1'b1;
    // both coil targets take the same scale
    next_st.coil_a = scale_coil(coil_a_in, factor);
    next_st.coil_b = scale_coil(coil_b_in, factor);
    next_st.irq = |(next_st.status & next_st.mask);
  end

  // =====================================================
  // state register
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end

  // =====================================================
  // adaptive stepper
  lacr_stepper u_step (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .sample(st.meas_new),
    .enable(adapt_en),
    .below(below),
    .at_or_above(at_or_above),
    .cfg(st.adapt),
    .cs(st.stall.cs),
    .factor(factor),
    .inc_ev(inc_ev),
    .dec_ev(dec_ev)
  );

  // outputs straight from flops; zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign coil_a_out = st.coil_a;
  assign coil_b_out = st.coil_b;
  assign stall_indicator_out = st.stall_flag;
  assign irq = st.irq;

  // =====================================================
  // checks
  property p_adapt_sel;
    @(posedge core_clk) disable iff (!rst_b)
      st.ph_valid && st.ph_write && st.ph_addr == LACR_OFS_WORD
      && hwdata[19:17] == 3'h5 |=> st.adapt.lower_thr == $past(hwdata[3:0]);
  endproperty
  a_adapt_sel: assert property (p_adapt_sel) else $error("adaptive word lost");
  property p_stall_sel;
    @(posedge core_clk) disable iff (!rst_b)
      st.ph_valid && st.ph_write && st.ph_addr == LACR_OFS_WORD
      && hwdata[19:17] == 3'h6 |=> st.stall.cs == $past(hwdata[4:0]);
  endproperty
  a_stall_sel: assert property (p_stall_sel) else $error("stall word lost");
  property p_raw;
    @(posedge core_clk) disable iff (!rst_b)
      !st.stall.filt_en && load_valid |=> st.load_meas == $past(load_in);
  endproperty
  a_raw: assert property (p_raw) else $error("raw sample missed");
  property p_filt;
    @(posedge core_clk) disable iff (!rst_b)
      st.stall.filt_en && !full_step |=> $stable(st.load_meas);
  endproperty
  a_filt: assert property (p_filt) else $error("filtered update early");
  property p_irq;
    @(posedge core_clk) disable iff (!rst_b)
      ##1 irq == |($past(next_st.status) & $past(next_st.mask));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  // read data must stand in the data phase right after the address phase
  property p_rd_scale;
    @(posedge core_clk) disable iff (!rst_b)
      rd_take && haddr[7:0] == LACR_OFS_SCALE
      |=> hrdata == 32'($past(factor));
  endproperty
  a_rd_scale: assert property (p_rd_scale) else $error("read data not in data phase");
  // a decrement event is never swallowed by a status clear
  property p_event_wins;
    @(posedge core_clk) disable iff (!rst_b)
      dec_ev |=> st.status[LACR_ST_DEC];
  endproperty
  a_event_wins: assert property (p_event_wins) else $error("decrement event lost");
  // upper level sits offset plus one units above the lower level
  property p_levels;
    @(posedge core_clk) disable iff (!rst_b)
      upper_lvl == lower_lvl
      + (((LOAD_W+2)'(st.adapt.upper_ofs) + (LOAD_W+2)'(1)) << LACR_THR_SHIFT);
  endproperty
  a_levels: assert property (p_levels) else $error("upper level wrong");
  // factor code 15 is sixteen of thirty-two: exactly half the target
  property p_coil_half;
    @(posedge core_clk) disable iff (!rst_b)
      factor == 5'h0F |=> coil_a_out == {1'b0, $past(coil_a_in[7:1])};
  endproperty
  a_coil_half: assert property (p_coil_half) else $error("coil scaling wrong");
  c_inc: cover property (@(posedge core_clk) inc_ev);
  c_stall: cover property (@(posedge core_clk) stall_indicator_out);
  c_irq: cover property (@(posedge core_clk) irq);
endmodule
`default_nettype wire

/* File: lacr_load_src.sv */
// model of the load measurement source that feeds the regulator
`default_nettype none
module lacr_load_src
#(
  parameter int LOAD_W = 10  // measurement width
)
(
  // clock
  input wire logic core_clk,
  // measurement side
  output logic [LOAD_W-1:0] load_in,
  output logic load_valid,
  output logic full_step
);
  timeunit 1ns;
  timeprecision 1ns;
  // =====================================================
  // idle state at time zero
  initial
  begin
    load_in = '0;
    load_valid = 1'b0;
    full_step = 1'b0;
  end
  // =====================================================
  // one strobe: raw sample, or full step when stp is set
  task automatic send(input logic [LOAD_W-1:0] v, input logic stp);
    load_in <= v;
    load_valid <= !stp;
    full_step <= stp;
    @(posedge core_clk);
    load_valid <= 1'b0;
    full_step <= 1'b0;
    // released value is not the last sample, so stale reads show up
    load_in <= ~v;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the load-adaptive current regulator
`default_nettype none
module tb_top
  import lacr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // =====================================================
  // design signals
  logic core_clk, rst_b, hsel, hwrite, hrdy, hresp, load_valid, full_step;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [9:0] load_in;
  logic [7:0] coil_a_in, coil_b_in, coil_a_out, coil_b_out;
  logic stall_indicator_out, irq;
  int n_errors = 0;
  int n_compared = 0;
  int f = 15;  // expected scaling factor
  logic [1:0] dc[4] = '{2'h3, 2'h1, 2'h2, 2'h0};  // decrement codes
  int dn[4] = '{1, 8, 2, 32};  // samples per decrement
  // =====================================================
  // design and source model
  lacr_top #(.LOAD_W(10)) i_lacr_top (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .load_in(load_in),
    .load_valid(load_valid), .full_step(full_step), .coil_a_in(coil_a_in),
    .coil_b_in(coil_b_in), .coil_a_out(coil_a_out), .coil_b_out(coil_b_out),
    .stall_indicator_out(stall_indicator_out), .irq(irq));
  lacr_load_src #(.LOAD_W(10)) i_lacr_load_src (.core_clk(core_clk), .load_in(load_in),
    .load_valid(load_valid), .full_step(full_step));
  // =====================================================
  // clock, 100 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // =====================================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // single word transfer, waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge core_clk);
    while (hrdy !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hrdy !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v, d);
    cyc(2);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 32'h0, d);
    chk(nm, d, exp);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic sc();
    rdc(LACR_OFS_SCALE, 32'(f), "factor");
  endtask
  task automatic ld(input logic [9:0] v, input logic stp);
    i_lacr_load_src.send(v, stp);
    cyc(3);
  endtask
  // reserved bits stay zero in both word builders
  function automatic logic [31:0] aw(logic mq, logic [1:0] dcd, logic [3:0] ofs,
                                     logic [1:0] inc, logic [3:0] lth);
    return {12'h0, 3'h5, 1'b0, mq, dcd, 1'b0, ofs, 1'b0, inc, 1'b0, lth};
  endfunction
  function automatic logic [31:0] sw(logic flt, logic [6:0] stall_threshold, logic [4:0] cs);
    return {12'h0, 3'h6, flt, 1'b0, stall_threshold, 3'h0, cs};
  endfunction
  // =====================================================
  // verdict, single exit point
  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog, run needs under five hundred cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    end_sim();
  end
  // =====================================================
  // test sequence
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    coil_a_in = 8'h80;
    coil_b_in = 8'h40;
    rst_b = 1'b0;
    cyc(20);
    rst_b <= 1'b1;
    cyc(1);
    // reset state and unmapped place
    rdc(LACR_OFS_MASK, 32'h0, "mask");
    wr(8'h20, 32'hF);
    rdc(8'h20, 32'h0, "unmapped");
    // scale word with adaptation off, then an unknown word pattern
    wr(LACR_OFS_WORD, sw(1'b0, 7'h00, 5'h0F));
    sc();
    wr(LACR_OFS_WORD, {12'h0, 3'h7, 17'h3});
    sc();
    chk("coil_a", {24'h0, coil_a_out}, 32'h40);
    chk("coil_b", {24'h0, coil_b_out}, 32'h20);
    // thresholds and interrupt on decrement
    bus(1'b0, LACR_OFS_STAT, 32'h0, d);
    wr(LACR_OFS_MASK, 32'h2);
    wr(LACR_OFS_WORD, aw(1'b0, 2'h3, 4'h1, 2'h0, 4'h2));
    ld(10'h080, 1'b0);
    f = 14;
    sc();
    chk("irq", {31'h0, irq}, 32'h1);
    rdc(LACR_OFS_STAT, 32'h2, "status");
    cyc(2);
    chk("irq", {31'h0, irq}, 32'h0);
    ld(10'h07F, 1'b0);
    sc();
    ld(10'h040, 1'b0);
    sc();
    ld(10'h03F, 1'b0);
    f = 15;
    sc();
    chk("irq", {31'h0, irq}, 32'h0);
    rdc(LACR_OFS_STAT, 32'h1, "status");
    // every decrement sample count
    for (int i = 0; i < 4; i++)
    begin
      wr(LACR_OFS_WORD, aw(1'b0, dc[i], 4'h1, 2'h0, 4'h2));
      repeat (dn[i] - 1) ld(10'h0C8, 1'b0);
      sc();
      ld(10'h0C8, 1'b0);
      f--;
      sc();
    end
    chk("coil_a", {24'h0, coil_a_out}, 32'h30);
    // floors: half then quarter, one sample per decrement
    wr(LACR_OFS_WORD, aw(1'b0, 2'h3, 4'h1, 2'h0, 4'h2));
    repeat (10) ld(10'h0C8, 1'b0);
    f = 7;
    sc();
    wr(LACR_OFS_WORD, aw(1'b1, 2'h3, 4'h1, 2'h0, 4'h2));
    repeat (6) ld(10'h0C8, 1'b0);
    f = 3;
    sc();
    // every increment step size, capped at the scale
    for (int i = 0; i < 4; i++)
    begin
      wr(LACR_OFS_WORD, aw(1'b1, 2'h3, 4'h1, 2'(i), 4'h2));
      ld(10'h03F, 1'b0);
      f = (f + (1 << i) > 15) ? 15 : f + (1 << i);
      sc();
    end
    // lower threshold zero switches adaptation off
    wr(LACR_OFS_WORD, aw(1'b0, 2'h3, 4'h1, 2'h0, 4'h0));
    ld(10'h0C8, 1'b0);
    sc();
    // stall indicator against threshold, rising edge as event
    bus(1'b0, LACR_OFS_STAT, 32'h0, d);
    wr(LACR_OFS_MASK, 32'h4);
    ld(10'h021, 1'b0);
    chk("stall", {31'h0, stall_indicator_out}, 32'h0);
    ld(10'h020, 1'b0);
    chk("stall", {31'h0, stall_indicator_out}, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    rdc(LACR_OFS_STAT, 32'h4, "status");
    // minus five stays above the advised lower limit
    wr(LACR_OFS_WORD, sw(1'b0, 7'h7B, 5'h0F));
    ld(10'h01C, 1'b0);
    chk("stall", {31'h0, stall_indicator_out}, 32'h0);
    ld(10'h01B, 1'b0);
    chk("stall", {31'h0, stall_indicator_out}, 32'h1);
    rdc(LACR_OFS_LOAD, 32'h1B, "load");
    // filtered mode: only the fourth full step updates
    wr(LACR_OFS_WORD, sw(1'b1, 7'h00, 5'h0F));
    ld(10'h005, 1'b0);
    repeat (3) ld(10'h009, 1'b1);
    rdc(LACR_OFS_LOAD, 32'h1B, "load");
    ld(10'h009, 1'b1);
    rdc(LACR_OFS_LOAD, 32'h9, "load");
    end_sim();
  end
endmodule
`default_nettype wire
